/* File: verilog/stlc_top.sv */
// Processor self-test controller with lockstep core compare and APB registers
//
// Overview of operation
// - A run is a series of independent intervals; software runs all of them or a chosen number.
// - A new run resumes after the last passed interval or restarts at the first, per software.
// - The core under test is isolated from the system for the whole run.
// - A failing interval has its number recorded in a readable status field.
// - A programmable timeout counter guards the run and ends one that runs too long.
// - Every run ends with a processor reset, after which software reads the status.
// - The test clock never exceeds 45 MHz and is divided from the processor clock.
// - Each interval takes 1365 test clock cycles, 35490 for all 26 intervals.
// - The outputs of the two cores are compared continuously and a mismatch is flagged.
// - Both core clock trees run at the same frequency and in phase.
// - The compared core signals are offset by two clock cycles before the compare.
// - The test clock divider takes ratios 2 to 8 from its divide field; a field asking for ratio 1 gives 2.
`timescale 1ns/100ps
`default_nettype none
module stlc_top #(
  parameter int CMP_W = 32,
  parameter int INT_CYC = stlc_pkg::INT_CYC,
  parameter int RST_CYC = stlc_pkg::RST_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CMP_W-1:0] core0_out,
  input wire logic [CMP_W-1:0] core1_out,
  input wire logic bist_pass,
  output logic core_isolate,
  output logic bist_tick,
  output logic [stlc_pkg::INT_W-1:0] bist_interval,
  output logic bist_interval_end,
  output logic core_clk_en,
  output logic cpu_reset_n,
  output logic lockstep_err
);
  localparam int IW = stlc_pkg::INT_W;
  localparam logic [IW-1:0] NI = stlc_pkg::NUM_INTERVALS;

  stlc_pkg::stlc_state_t state_q, state_d;
  logic [IW-1:0] nint_q, nint_d;
  logic restart_q, restart_d;
  logic [stlc_pkg::DIV_W-1:0] div_q, div_d;
  logic [31:0] tmo_q, tmo_d;
  logic [IW-1:0] cur_q, cur_d;
  logic [IW-1:0] last_q, last_d;
  logic [IW-1:0] cnt_q, cnt_d;
  logic [IW-1:0] fint_q, fint_d;
  logic done_q, done_d;
  logic fail_q, fail_d;
  logic tout_q, tout_d;
  logic [15:0] cyc_q, cyc_d;
  logic [3:0] dcnt_q, dcnt_d;
  logic [31:0] tcnt_q, tcnt_d;
  logic [15:0] rcnt_q, rcnt_d;
  logic [31:0] prdata_q, prdata_d;
  logic mis_q, mis_d;
  logic [CMP_W-1:0] dly_q [stlc_pkg::CMP_DELAY];
  logic wr_en, setup, hit, start;
  logic [3:0] ratio;
  logic tick, iend, expire;

  // APB decode; writes land in the access phase, reads are captured at setup
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  always_comb begin
    hit = (paddr == stlc_pkg::ADDR_CTRL) || (paddr == stlc_pkg::ADDR_STATUS) ||
          (paddr == stlc_pkg::ADDR_DIVIDE_RATIO_FIELD) || (paddr == stlc_pkg::ADDR_TIMEOUT) ||
          (paddr == stlc_pkg::ADDR_CMP);
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_q;
  assign start = wr_en & (paddr == stlc_pkg::ADDR_CTRL) & pwdata[stlc_pkg::CTRL_START] &
                 (state_q == stlc_pkg::ST_IDLE);

  // Divide ratio is never below the least ratio that keeps the test clock in range
  always_comb begin
    ratio = {1'b0, div_q} + 4'h1;
    if (ratio < 4'(stlc_pkg::MIN_DIV)) begin
      ratio = 4'(stlc_pkg::MIN_DIV);
    end
  end
  assign tick = (state_q == stlc_pkg::ST_RUN) && (dcnt_q == ratio - 4'h1);
  assign iend = tick && (cyc_q == 16'(INT_CYC - 1));
  assign expire = (state_q == stlc_pkg::ST_RUN) && (tcnt_q >= tmo_q);

  // Core outputs while under test, the clock enable is shared so both trees stay in phase
  assign core_isolate = (state_q != stlc_pkg::ST_IDLE);
  assign core_clk_en = (state_q == stlc_pkg::ST_RUN) ? tick : 1'b1;
  assign bist_tick = tick;
  assign bist_interval = cur_q;
  assign bist_interval_end = iend;
  assign cpu_reset_n = (state_q != stlc_pkg::ST_RESET);
  assign lockstep_err = mis_q;

  // Register file and read data
  always_comb begin
    nint_d = nint_q;
    restart_d = restart_q;
    div_d = div_q;
    tmo_d = tmo_q;
    prdata_d = prdata_q;
    if (wr_en && paddr == stlc_pkg::ADDR_CTRL && state_q == stlc_pkg::ST_IDLE) begin
      nint_d = pwdata[stlc_pkg::CTRL_NINT_LSB +: IW];
      restart_d = pwdata[stlc_pkg::CTRL_RESTART];
    end
    if (wr_en && paddr == stlc_pkg::ADDR_DIVIDE_RATIO_FIELD) begin
      div_d = pwdata[stlc_pkg::DIV_LSB +: stlc_pkg::DIV_W];
    end
    if (wr_en && paddr == stlc_pkg::ADDR_TIMEOUT) begin
      tmo_d = pwdata;
    end
    if (setup) begin
      prdata_d = 32'h0;
      case (paddr)
        stlc_pkg::ADDR_CTRL: begin
          prdata_d[stlc_pkg::CTRL_RESTART] = restart_q;
          prdata_d[stlc_pkg::CTRL_NINT_LSB +: IW] = nint_q;
        end
        stlc_pkg::ADDR_STATUS: begin
          prdata_d[stlc_pkg::ST_DONE] = done_q;
          prdata_d[stlc_pkg::ST_FAIL] = fail_q;
          prdata_d[stlc_pkg::ST_TIMEOUT] = tout_q;
          prdata_d[stlc_pkg::ST_FINT_LSB +: IW] = fint_q;
          prdata_d[stlc_pkg::ST_LAST_LSB +: IW] = last_q;
        end
        stlc_pkg::ADDR_DIVIDE_RATIO_FIELD: prdata_d[stlc_pkg::DIV_LSB +: stlc_pkg::DIV_W] = div_q;
        stlc_pkg::ADDR_TIMEOUT: prdata_d = tmo_q;
        stlc_pkg::ADDR_CMP: prdata_d[0] = mis_q;
        default: prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nint_q <= 5'h0;
      restart_q <= 1'b0;
      div_q <= stlc_pkg::DIV_RST;
      tmo_q <= stlc_pkg::TIMEOUT_RST;
      prdata_q <= 32'h0;
    end else begin
      nint_q <= nint_d;
      restart_q <= restart_d;
      div_q <= div_d;
      tmo_q <= tmo_d;
      prdata_q <= prdata_d;
    end
  end

  // Sequencer: intervals, timeout, completion reset
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    last_d = last_q;
    cnt_d = cnt_q;
    fint_d = fint_q;
    done_d = done_q;
    fail_d = fail_q;
    tout_d = tout_q;
    cyc_d = cyc_q;
    dcnt_d = dcnt_q;
    tcnt_d = tcnt_q;
    rcnt_d = rcnt_q;
    case (state_q)
      stlc_pkg::ST_IDLE: begin
        if (start) begin
          state_d = stlc_pkg::ST_RUN;
          // Resume past the last interval, or start over when told to or when all ran
          cur_d = (pwdata[stlc_pkg::CTRL_RESTART] || last_q >= NI) ? 5'h0 : last_q;
          if (pwdata[stlc_pkg::CTRL_RESTART]) begin
            last_d = 5'h0;
          end
          cnt_d = 5'h0;
          done_d = 1'b0;
          fail_d = 1'b0;
          tout_d = 1'b0;
          fint_d = 5'h0;
          cyc_d = 16'h0;
          dcnt_d = 4'h0;
          tcnt_d = 32'h0;
        end
      end
      stlc_pkg::ST_RUN: begin
        tcnt_d = tcnt_q + 32'h1;
        dcnt_d = tick ? 4'h0 : dcnt_q + 4'h1;
        if (tick) begin
          cyc_d = iend ? 16'h0 : cyc_q + 16'h1;
        end
        if (expire) begin
          tout_d = 1'b1;
          state_d = stlc_pkg::ST_RESET;
          rcnt_d = 16'h0;
        end else if (iend) begin
          if (!bist_pass) begin
            fail_d = 1'b1;
            fint_d = cur_q + 5'h1;
            state_d = stlc_pkg::ST_RESET;
            rcnt_d = 16'h0;
          end else begin
            last_d = cur_q + 5'h1;
            cur_d = cur_q + 5'h1;
            cnt_d = cnt_q + 5'h1;
            // A zero count runs every remaining interval
            if ((cnt_q + 5'h1 == nint_q) || (cur_q + 5'h1 >= NI)) begin
              state_d = stlc_pkg::ST_RESET;
              rcnt_d = 16'h0;
            end
          end
        end
      end
      stlc_pkg::ST_RESET: begin
        rcnt_d = rcnt_q + 16'h1;
        if (rcnt_q == 16'(RST_CYC - 1)) begin
          done_d = 1'b1;
          state_d = stlc_pkg::ST_IDLE;
        end
      end
      default: state_d = stlc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= stlc_pkg::ST_IDLE;
      cur_q <= 5'h0;
      last_q <= 5'h0;
      cnt_q <= 5'h0;
      fint_q <= 5'h0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      tout_q <= 1'b0;
      cyc_q <= 16'h0;
      dcnt_q <= 4'h0;
      tcnt_q <= 32'h0;
      rcnt_q <= 16'h0;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      last_q <= last_d;
      cnt_q <= cnt_d;
      fint_q <= fint_d;
      done_q <= done_d;
      fail_q <= fail_d;
      tout_q <= tout_d;
      cyc_q <= cyc_d;
      dcnt_q <= dcnt_d;
      tcnt_q <= tcnt_d;
      rcnt_q <= rcnt_d;
    end
  end

  // Lockstep compare: the first core is delayed to line up with the second
  genvar g;
  generate
    for (g = 0; g < stlc_pkg::CMP_DELAY; g++) begin : g_dly
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dly_q[g] <= '0;
        end else begin
          dly_q[g] <= (g == 0) ? core0_out : dly_q[(g > 0) ? g - 1 : 0];
        end
      end
    end
  endgenerate

  // Sticky mismatch; a new mismatch wins over a clear in the same cycle
  always_comb begin
    mis_d = mis_q;
    if (wr_en && paddr == stlc_pkg::ADDR_CMP && pwdata[0]) begin
      mis_d = 1'b0;
    end
    if (dly_q[stlc_pkg::CMP_DELAY-1] != core1_out) begin
      mis_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mis_q <= 1'b0;
    end else begin
      mis_q <= mis_d;
    end
  end

  // Checks
  chk_isolate_run: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == stlc_pkg::ST_RUN |-> core_isolate && cpu_reset_n)
    else $error("core not isolated during run");
  chk_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick)
    else $error("test clock faster than allowed");
  chk_div_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    tick && $stable(div_q) |-> dcnt_q == ratio - 4'h1 && ratio >= 4'h2 && ratio <= 4'h8)
    else $error("divide ratio out of range");
  chk_interval_len: assert property (@(posedge pclk) disable iff (!presetn)
    iend && bist_pass && !expire |=> cyc_q == 16'h0 && bist_interval == $past(cur_q) + 5'h1)
    else $error("next interval not started afresh");
  chk_cmp_offset: assert property (@(posedge pclk) disable iff (!presetn)
    $past(core0_out, 2) != core1_out && $past(presetn, 2) |=> mis_q)
    else $error("mismatch not flagged");
  chk_fail_record: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == stlc_pkg::ST_RUN && iend && !bist_pass && !expire
    |=> fail_q && fint_q == $past(cur_q) + 5'h1 && state_q == stlc_pkg::ST_RESET)
    else $error("failing interval not recorded");
  chk_timeout_abort: assert property (@(posedge pclk) disable iff (!presetn)
    expire |=> tout_q && !cpu_reset_n)
    else $error("timeout did not abort");
  chk_reset_end: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cpu_reset_n) |-> !cpu_reset_n [*8])
    else $error("completion reset too short");
  chk_resume_from: assert property (@(posedge pclk) disable iff (!presetn)
    start && !pwdata[stlc_pkg::CTRL_RESTART] && last_q < NI |=> cur_q == $past(last_q))
    else $error("resume did not continue");
  chk_count_stop: assert property (@(posedge pclk) disable iff (!presetn)
    iend && bist_pass && !expire && cnt_q + 5'h1 == nint_q |=> state_q == stlc_pkg::ST_RESET)
    else $error("run did not stop at count");
  chk_clk_phase: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == stlc_pkg::ST_IDLE |-> core_clk_en)
    else $error("core clock gated while idle");
endmodule : stlc_top
`default_nettype wire

/* File: verilog/stlc_pkg.sv */
// Constants for the processor self-test and lockstep compare block
`default_nettype none
package stlc_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_CTRL = 32'h0fffe100;
  localparam logic [31:0] ADDR_STATUS = 32'h0fffe104;
  localparam logic [31:0] ADDR_DIVIDE_RATIO_FIELD = 32'h0fffe108;
  localparam logic [31:0] ADDR_TIMEOUT = 32'h0fffe10c;
  localparam logic [31:0] ADDR_CMP = 32'h0fffe110;
  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_NINT_LSB = 8;
  // Status fields
  localparam int ST_DONE = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_FINT_LSB = 8;
  localparam int ST_LAST_LSB = 16;
  // Divider field, ratio is field plus one
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  // Reset values
  localparam logic [DIV_W-1:0] DIV_RST = 3'h1;
  localparam logic [31:0] TIMEOUT_RST = 32'hffffffff;
  // Interval figures
  localparam int INT_W = 5;
  localparam logic [INT_W-1:0] NUM_INTERVALS = 5'h1a;
  localparam int INT_CYC = 1365;
  localparam int TOTAL_CYC = 35490;
  // Clock rates and the derived least divide ratio
  localparam int PCLK_MHZ = 50;
  localparam int STCLK_MAX_MHZ = 45;
  localparam int MIN_DIV = (PCLK_MHZ + STCLK_MAX_MHZ - 1) / STCLK_MAX_MHZ;
  // Core compare offset and completion reset width
  localparam int CMP_DELAY = 2;
  localparam int RST_CYC = 16;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RESET} stlc_state_t;
endpackage : stlc_pkg
`default_nettype wire

/* File: sim/stlc_cores.sv */
// Model of the two lockstepped cores and the test engine verdict
`timescale 1ns/100ps
`default_nettype none
module stlc_cores #(
  parameter int CMP_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic core_clk_en,
  input wire logic [4:0] bist_interval,
  input wire logic [4:0] fail_at,
  input wire logic flip,
  output logic [CMP_W-1:0] core0_out,
  output logic [CMP_W-1:0] core1_out,
  output logic bist_pass
);
  logic [CMP_W-1:0] cnt_q, cnt_d, d1_q, d1_d, d2_q, d2_d;
  // One shared enable keeps both cores in step; the second lags two cycles
  always_comb begin
    cnt_d = core_clk_en ? cnt_q + 1'b1 : cnt_q;
    d1_d = cnt_q;
    d2_d = d1_q;
  end
  // Both cores start from the same state so no false mismatch arises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      d1_q <= '0;
      d2_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      d1_q <= d1_d;
      d2_q <= d2_d;
    end
  end
  // Flip upsets the second core only while the bench asks for it
  assign core0_out = cnt_q;
  assign core1_out = d2_q ^ {CMP_W{flip}};
  // Zero means every interval passes, else interval fail_at (1-based) fails
  assign bist_pass = !(fail_at != 5'h0 && bist_interval == fail_at - 5'h1);
endmodule : stlc_cores
`default_nettype wire

/* File: sim/test_stlc_top.sv */
// Self-checking bench for the self-test and lockstep compare block
`timescale 1ns/100ps
`default_nettype none
module test_stlc_top;
  localparam int INT_CYC = 8;
  localparam int RST_CYC = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] fail_at = 5'h0;
  logic flip = 1'b0;
  logic [31:0] prdata, c0, c1, rd;
  logic pready, pslverr, bist_pass, core_isolate, bist_tick, bist_interval_end;
  logic core_clk_en, cpu_reset_n, lockstep_err, err;
  logic [4:0] bist_interval;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int ticks, ends, mingap, first_idx, rlow, ens;

  always #10 pclk = ~pclk;

  stlc_top #(.CMP_W(32), .INT_CYC(INT_CYC), .RST_CYC(RST_CYC)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core0_out(c0), .core1_out(c1), .bist_pass(bist_pass), .core_isolate(core_isolate),
    .bist_tick(bist_tick), .bist_interval(bist_interval),
    .bist_interval_end(bist_interval_end), .core_clk_en(core_clk_en),
    .cpu_reset_n(cpu_reset_n), .lockstep_err(lockstep_err));

  stlc_cores #(.CMP_W(32)) i_cores (
    .pclk(pclk), .presetn(presetn), .core_clk_en(core_clk_en),
    .bist_interval(bist_interval), .fail_at(fail_at), .flip(flip),
    .core0_out(c0), .core1_out(c1), .bist_pass(bist_pass));

  task automatic test_done();
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One APB transfer; read data and error are taken at the pready edge
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] ctrl(input int n, input logic rs);
    return (32'(n) << stlc_pkg::CTRL_NINT_LSB) | (32'(rs) << stlc_pkg::CTRL_RESTART) | 32'h1;
  endfunction : ctrl

  // Start a run and watch it until the completion reset is over
  task automatic run(input logic [31:0] cw);
    int last;
    ticks = 0;
    ends = 0;
    mingap = 99;
    first_idx = -1;
    rlow = 0;
    ens = 0;
    last = 0;
    apb(1'b1, stlc_pkg::ADDR_CTRL, cw);
    for (int c = 1; c < 3000; c++) begin
      @(posedge pclk);
      if (cpu_reset_n === 1'b0) rlow++;
      else if (rlow > 0) break;
      else if (core_isolate !== 1'b1) check("core_isolate", 32'h1, 32'h0);
      // Core clock pulses outside the completion reset must be test clock cycles only
      if (cpu_reset_n === 1'b1 && core_clk_en === 1'b1) ens++;
      if (bist_tick === 1'b1) begin
        if (ticks > 0 && c - last < mingap) mingap = c - last;
        last = c;
        ticks++;
      end
      if (bist_interval_end === 1'b1) begin
        if (ends == 0) first_idx = bist_interval;
        ends++;
      end
    end
    check("reset_len", RST_CYC, rlow);
  endtask : run

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, stlc_pkg::ADDR_DIVIDE_RATIO_FIELD, 32'h0);
    check("divide_ratio_field_rst", 32'h1, rd);
    apb(1'b0, stlc_pkg::ADDR_TIMEOUT, 32'h0);
    check("timeout_rst", 32'hffffffff, rd);
    apb(1'b0, 32'h0fffe1f0, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, err});
    // Two intervals from the first, ratio 2
    apb(1'b1, stlc_pkg::ADDR_DIVIDE_RATIO_FIELD, 32'h1);
    run(ctrl(2, 1'b1));
    check("ticks", 2 * INT_CYC, ticks);
    check("ends", 32'h2, ends);
    check("core_clk_en", 2 * INT_CYC, ens);
    check("reset_released", 32'h1, {31'h0, cpu_reset_n});
    check("tick_gap", 32'h2, mingap);
    apb(1'b0, stlc_pkg::ADDR_STATUS, 32'h0);
    check("status", 32'h1, rd & 32'h7);
    run(ctrl(1, 1'b0));
    check("resume_idx", 32'h2, first_idx);
    apb(1'b1, stlc_pkg::ADDR_DIVIDE_RATIO_FIELD, 32'h7);
    run(ctrl(1, 1'b1));
    check("tick_gap8", 32'h8, mingap);
    // Ratio 1 asked for must still respect the test clock ceiling
    apb(1'b1, stlc_pkg::ADDR_DIVIDE_RATIO_FIELD, 32'h0);
    fail_at <= 5'h2;
    run(ctrl(0, 1'b1));
    check("tick_gap_min", 32'h2, mingap);
    check("fail_ticks", 2 * INT_CYC, ticks);
    apb(1'b0, stlc_pkg::ADDR_STATUS, 32'h0);
    check("fail_status", 32'h203, rd & 32'h1f07);
    fail_at <= 5'h0;
    apb(1'b1, stlc_pkg::ADDR_TIMEOUT, 32'h14);
    run(ctrl(0, 1'b1));
    check("aborted", 32'h1, {31'h0, ticks < 2 * INT_CYC});
    apb(1'b0, stlc_pkg::ADDR_STATUS, 32'h0);
    check("timeout_status", 32'h5, rd & 32'h7);
    check("no_mismatch", 32'h0, {31'h0, lockstep_err});
    flip <= 1'b1;
    @(posedge pclk);
    flip <= 1'b0;
    repeat (3) @(posedge pclk);
    check("lockstep_err", 32'h1, {31'h0, lockstep_err});
    apb(1'b0, stlc_pkg::ADDR_CMP, 32'h0);
    check("cmp_flag", 32'h1, rd & 32'h1);
    apb(1'b1, stlc_pkg::ADDR_CMP, 32'h1);
    apb(1'b0, stlc_pkg::ADDR_CMP, 32'h0);
    check("cmp_clear", 32'h0, rd & 32'h1);
    test_done();
  end
endmodule : test_stlc_top
`default_nettype wire
